//--- design/gptc_cfg.svh
`ifndef GPTC_CFG_SVH
`define GPTC_CFG_SVH

// channel count and counter width
`define GPTC_NCH 2
`define GPTC_CNT_W 16
`define GPTC_MODE_W 3

// mode codes, code is the mode number minus one
`define GPTC_MODE_EVENT 3'h0
`define GPTC_MODE_PERIOD 3'h1
`define GPTC_MODE_WIDTH 3'h2
`define GPTC_MODE_GATED_PULSE 3'h3
`define GPTC_MODE_TRIG_PULSE 3'h4
`define GPTC_MODE_RETRIG 3'h5
`define GPTC_MODE_TRIG_CONT 3'h6
`define GPTC_MODE_CONT_GATED 3'h7

// reset value and phase step of one
`define GPTC_CNT_RST 16'h0000
`define GPTC_PH_ONE 16'h0001

// internal counter clock: 100 ns period from the 10 ns reference
`define GPTC_REF_PERIOD_NS 10
`define GPTC_INT_PERIOD_NS 100
`define GPTC_INT_DIV (`GPTC_INT_PERIOD_NS / `GPTC_REF_PERIOD_NS)
`define GPTC_DIV_W 8
`define GPTC_DIV_RST 8'h00
`endif

//--- design/gptc_pkg.sv
package gptc_pkg;
  // channel sequencer states, one-hot
  typedef enum logic [5:0] {
    GPTC_ST_IDLE = 6'h01,
    GPTC_ST_ARMED = 6'h02,
    GPTC_ST_MEAS = 6'h04,
    GPTC_ST_DELAY = 6'h08,
    GPTC_ST_WIDTH = 6'h10,
    GPTC_ST_DONE = 6'h20
  } gptc_state_t;
endpackage : gptc_pkg

//--- design/gptc_sync.sv
`timescale 1ns/10ps
`default_nettype none
module gptc_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // asynchronous levels in
  input wire logic [W-1:0] async_in,
  // synchronised levels out
  output logic [W-1:0] sync_out
);
  // first stage, read only by the second
  logic [W-1:0] meta_q;
  // second stage
  logic [W-1:0] sync_q;

  // two flip-flop synchroniser
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule : gptc_sync
`default_nettype wire

//--- design/gptc_edge.sv
`timescale 1ns/10ps
`default_nettype none
module gptc_edge #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // synchronous level in
  input wire logic [W-1:0] level_in,
  // one-cycle edge pulses
  output logic [W-1:0] rise_out,
  output logic [W-1:0] fall_out
);
  // level one cycle ago
  logic [W-1:0] prev_q;
  logic [W-1:0] prev_d;
  // low in the first cycle after reset, when prev_q does not hold a real level yet
  logic primed_q;
  logic primed_d;

  // next value is simply the present level
  always_comb begin
    prev_d = level_in;
    primed_d = 1'b1;
  end

  // register the previous level
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      prev_q <= '0;
      primed_q <= 1'b0;
    end else begin
      prev_q <= prev_d;
      primed_q <= primed_d;
    end
  end

  // edges compare present and past level; an inverted idle level is no edge after reset
  assign rise_out = level_in & ~prev_q & {W{primed_q}};
  assign fall_out = ~level_in & prev_q & {W{primed_q}};
endmodule : gptc_edge
`default_nettype wire

//--- design/gptc_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "gptc_cfg.svh"
module gptc_top #(
  parameter int NCH = `GPTC_NCH,
  parameter int CW = `GPTC_CNT_W,
  parameter int INT_DIV = `GPTC_INT_DIV
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // counter pins, asynchronous to ref_clk
  input wire logic [NCH-1:0] counter_clock_in,
  input wire logic [NCH-1:0] counter_gate_in,
  input wire logic [NCH-1:0] count_direction_in,
  // counter output pins
  output logic [NCH-1:0] counter_pulse_out,
  // software commands, one-cycle pulses
  input wire logic [NCH-1:0] sw_start,
  input wire logic [NCH-1:0] sw_reset,
  // source selection
  input wire logic [NCH-1:0] clk_src_ext,
  input wire logic [NCH-1:0] dir_sw_sel,
  input wire logic [NCH-1:0] sw_dir_up,
  input wire logic [NCH-1:0] gate_sw_sel,
  input wire logic [NCH-1:0] sw_gate,
  // polarity selection, set means active low
  input wire logic [NCH-1:0] clk_pol_low,
  input wire logic [NCH-1:0] gate_pol_low,
  input wire logic [NCH-1:0] dir_pol_low,
  input wire logic [NCH-1:0] out_pol_low,
  // mode and counts
  input wire logic [NCH-1:0][`GPTC_MODE_W-1:0] mode_sel,
  input wire logic [NCH-1:0][CW-1:0] init_count,
  input wire logic [NCH-1:0][CW-1:0] pulse_delay,
  input wire logic [NCH-1:0][CW-1:0] pulse_width,
  // status
  output logic [NCH-1:0][CW-1:0] count_value,
  output logic [NCH-1:0] meas_done,
  output logic [NCH-1:0] running
);

  // synchronised pin levels
  logic [NCH-1:0] clk_sync;
  logic [NCH-1:0] gate_sync;
  logic [NCH-1:0] dir_sync;
  // polarity-corrected levels
  logic [NCH-1:0] clk_lvl;
  logic [NCH-1:0] gate_lvl;
  // detected edges of active levels
  logic [NCH-1:0] clk_rise;
  logic [NCH-1:0] gate_rise;
  logic [NCH-1:0] gate_fall;
  // internal divider
  logic [`GPTC_DIV_W-1:0] div_q;
  logic [`GPTC_DIV_W-1:0] div_d;
  logic int_tick;

  // step the count by one in the chosen direction
  function automatic logic [CW-1:0] gptc_step(input logic [CW-1:0] v, input logic up);
    logic [CW-1:0] one;
    one = {{(CW-1){1'b0}}, 1'b1};
    gptc_step = up ? v + one : v - one;
  endfunction : gptc_step

  gptc_sync #(
    .W(3 * NCH)
  ) u_sync (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .async_in({counter_clock_in, counter_gate_in, count_direction_in}),
    .sync_out({clk_sync, gate_sync, dir_sync})
  );

  assign clk_lvl = clk_sync ^ clk_pol_low;

  assign gate_lvl = (gate_sw_sel & sw_gate) | (~gate_sw_sel & (gate_sync ^ gate_pol_low));

  gptc_edge #(
    .W(NCH)
  ) u_clk_edge (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .level_in(clk_lvl),
    .rise_out(clk_rise),
    .fall_out()
  );

  // gate edge detection, both edges used
  gptc_edge #(
    .W(NCH)
  ) u_gate_edge (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .level_in(gate_lvl),
    .rise_out(gate_rise),
    .fall_out(gate_fall)
  );

  // internal clock divider, shared by both channels
  always_comb begin
    if (div_q == `GPTC_DIV_W'(INT_DIV - 1)) begin
      // wrap at the end of the internal period
      div_d = `GPTC_DIV_RST;
    end else begin
      div_d = div_q + 1'b1;
    end
  end

  // divider register
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      div_q <= `GPTC_DIV_RST;
    end else begin
      div_q <= div_d;
    end
  end

  // one reference cycle per internal period
  assign int_tick = (div_q == `GPTC_DIV_W'(INT_DIV - 1));

  for (genvar ch = 0; ch < NCH; ch++) begin : g_chan
    // sequencer state
    gptc_pkg::gptc_state_t state_q;
    gptc_pkg::gptc_state_t state_d;
    // live count
    logic [CW-1:0] count_q;
    logic [CW-1:0] count_d;
    // delay and width phase counter
    logic [CW-1:0] ph_q;
    logic [CW-1:0] ph_d;
    // active output level before polarity
    logic act_q;
    logic act_d;
    // measurement complete flag
    logic done_q;
    logic done_d;
    // output pin register
    logic pin_q;
    logic pin_d;
    // per-channel helpers
    logic tick;
    logic up;
    logic gate_on;
    logic gated_mode;
    logic run;
    logic [`GPTC_MODE_W-1:0] mode;

    assign mode = mode_sel[ch];

    assign tick = clk_src_ext[ch] ? clk_rise[ch] : int_tick;

    assign up = dir_sw_sel[ch] ? sw_dir_up[ch] : (dir_sync[ch] ^ dir_pol_low[ch]);

    // present gate level
    assign gate_on = gate_lvl[ch];

    // modes whose pulse timing pauses with the gate
    assign gated_mode = (mode == `GPTC_MODE_GATED_PULSE) || (mode == `GPTC_MODE_CONT_GATED);

    // pulse phase counting enable
    assign run = tick && (!gated_mode || gate_on);

    // sequencer next-state logic
    always_comb begin
      state_d = state_q;
      count_d = count_q;
      ph_d = ph_q;
      act_d = act_q;
      done_d = done_q;
      if (sw_reset[ch]) begin
        state_d = gptc_pkg::GPTC_ST_IDLE;
        count_d = init_count[ch];
        ph_d = `GPTC_CNT_RST;
        act_d = 1'b0;
        done_d = 1'b0;
      end else if (sw_start[ch]) begin
        act_d = 1'b0;
        done_d = 1'b0;
        ph_d = pulse_delay[ch];
        unique case (mode)
          `GPTC_MODE_EVENT: state_d = gptc_pkg::GPTC_ST_MEAS;
          `GPTC_MODE_GATED_PULSE: state_d = gptc_pkg::GPTC_ST_DELAY;
          `GPTC_MODE_CONT_GATED: state_d = gptc_pkg::GPTC_ST_DELAY;
          // triggered and measuring modes wait a gate edge
          default: state_d = gptc_pkg::GPTC_ST_ARMED;
        endcase
      end else begin
        unique case (state_q)
          // halted until a start
          gptc_pkg::GPTC_ST_IDLE: begin
            state_d = gptc_pkg::GPTC_ST_IDLE;
          end
          // waiting for the first active gate edge
          gptc_pkg::GPTC_ST_ARMED: begin
            if (gate_rise[ch]) begin
              if ((mode == `GPTC_MODE_PERIOD) || (mode == `GPTC_MODE_WIDTH)) begin
                // measurement interval opens
                state_d = gptc_pkg::GPTC_ST_MEAS;
              end else begin
                state_d = gptc_pkg::GPTC_ST_DELAY;
                ph_d = pulse_delay[ch];
              end
            end
          end
          // counting and measuring
          gptc_pkg::GPTC_ST_MEAS: begin
            if (mode == `GPTC_MODE_PERIOD) begin
              if (gate_rise[ch]) begin
                state_d = gptc_pkg::GPTC_ST_DONE;
                act_d = 1'b1;
                done_d = 1'b1;
              end else if (tick) begin
                count_d = gptc_step(count_q, up);
              end
            end else if (mode == `GPTC_MODE_WIDTH) begin
              if (gate_fall[ch]) begin
                state_d = gptc_pkg::GPTC_ST_DONE;
                act_d = 1'b1;
                done_d = 1'b1;
              end else if (tick && gate_on) begin
                // count only while gate active
                count_d = gptc_step(count_q, up);
              end
            end else begin
              if (tick && gate_on) begin
                count_d = gptc_step(count_q, up);
              end
            end
          end
          // pulse delay or interval phase
          gptc_pkg::GPTC_ST_DELAY: begin
            if (run) begin
              count_d = gptc_step(count_q, up);
              if (ph_q <= `GPTC_PH_ONE) begin
                // delay over, pulse goes active
                state_d = gptc_pkg::GPTC_ST_WIDTH;
                ph_d = pulse_width[ch];
                act_d = 1'b1;
              end else begin
                ph_d = ph_q - `GPTC_PH_ONE;
              end
            end
          end
          // pulse active phase
          gptc_pkg::GPTC_ST_WIDTH: begin
            if (run) begin
              count_d = gptc_step(count_q, up);
              if (ph_q <= `GPTC_PH_ONE) begin
                act_d = 1'b0;
                ph_d = pulse_delay[ch];
                if (mode == `GPTC_MODE_RETRIG) begin
                  state_d = gptc_pkg::GPTC_ST_ARMED;
                end else if ((mode == `GPTC_MODE_TRIG_CONT)
                             || (mode == `GPTC_MODE_CONT_GATED)) begin
                  state_d = gptc_pkg::GPTC_ST_DELAY;
                end else begin
                  state_d = gptc_pkg::GPTC_ST_DONE;
                  done_d = 1'b1;
                end
              end else begin
                ph_d = ph_q - `GPTC_PH_ONE;
              end
            end
          end
          // finished, gate edges ignored until a start
          gptc_pkg::GPTC_ST_DONE: begin
            state_d = gptc_pkg::GPTC_ST_DONE;
          end
          // an illegal code falls back to halt
          default: begin
            state_d = gptc_pkg::GPTC_ST_IDLE;
            act_d = 1'b0;
          end
        endcase
      end
      pin_d = act_d ^ out_pol_low[ch];
    end

    // sequencer registers
    always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
        state_q <= gptc_pkg::GPTC_ST_IDLE;
        count_q <= `GPTC_CNT_RST;
        ph_q <= `GPTC_CNT_RST;
        act_q <= 1'b0;
        done_q <= 1'b0;
        pin_q <= 1'b0;
      end else begin
        state_q <= state_d;
        count_q <= count_d;
        ph_q <= ph_d;
        act_q <= act_d;
        done_q <= done_d;
        pin_q <= pin_d;
      end
    end

    assign count_value[ch] = count_q;
    assign meas_done[ch] = done_q;
    assign counter_pulse_out[ch] = pin_q;
    // busy whenever not halted or finished
    assign running[ch] = !(state_q == gptc_pkg::GPTC_ST_IDLE)
                         && !(state_q == gptc_pkg::GPTC_ST_DONE);
  end : g_chan

endmodule : gptc_top
`default_nettype wire

//--- bench/gptc_top_sva.sv
`timescale 1ns/10ps
`default_nettype none
`include "gptc_cfg.svh"
// port checker, channel 0
module gptc_top_chk #(
  parameter int NCH = 2,
  parameter int CW = 16
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // controls
  input wire logic [NCH-1:0] sw_start,
  input wire logic [NCH-1:0] sw_reset,
  input wire logic [NCH-1:0] dir_sw_sel,
  input wire logic [NCH-1:0] sw_dir_up,
  input wire logic [NCH-1:0] out_pol_low,
  input wire logic [NCH-1:0][`GPTC_MODE_W-1:0] mode_sel,
  input wire logic [NCH-1:0][CW-1:0] init_count,
  // status and pins
  input wire logic [NCH-1:0][CW-1:0] count_value,
  input wire logic [NCH-1:0] counter_pulse_out,
  input wire logic [NCH-1:0] meas_done,
  input wire logic [NCH-1:0] running
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  a_reset_quiet: assert property ($rose(resetn) |-> count_value[0] == '0
    && !running[0] && !meas_done[0] && counter_pulse_out == '0) else $error("not idle");
  a_reload_halt: assert property (sw_reset[0] |=> count_value[0] == $past(init_count[0])
    && !running[0] && !meas_done[0]) else $error("no reload");
  a_start_runs: assert property (sw_start[0] && !sw_reset[0] |=> running[0] && !meas_done[0])
    else $error("no start");
  a_halt_holds: assert property (!running[0] && !sw_start[0] && !sw_reset[0]
    |=> $stable(count_value[0])) else $error("halted count moved");
  a_unit_step: assert property (!sw_reset[0] |=>
    CW'(count_value[0] - $past(count_value[0])) inside {16'h0000, 16'h0001, 16'hffff})
    else $error("step too large");
  a_sw_dir_up: assert property (dir_sw_sel[0] && sw_dir_up[0] && $stable(sw_dir_up[0])
    && !sw_reset[0] |=> count_value[0] != $past(count_value[0]) - 16'h0001)
    else $error("counted down");
  a_idle_out: assert property (!running[0] && !meas_done[0] && !sw_start[0]
    && !sw_reset[0] && $stable(out_pol_low[0]) |=> counter_pulse_out[0] == $past(out_pol_low[0]))
    else $error("idle pin active");
  a_meas_out: assert property ($rose(meas_done[0]) && mode_sel[0] inside {3'h1, 3'h2}
    |-> ##[0:1] counter_pulse_out[0] != out_pol_low[0]) else $error("no end flag");
  a_pulse_end: assert property ($rose(meas_done[0]) && mode_sel[0] inside {3'h3, 3'h4}
    |-> ##[0:1] counter_pulse_out[0] == out_pol_low[0]) else $error("pulse left on");
  a_done_cause: assert property ($rose(meas_done[0]) |-> $past(running[0]))
    else $error("done while halted");
  c_meas: cover property ($rose(meas_done[0]) && mode_sel[0] == 3'h1);
  c_pulse: cover property ($rose(counter_pulse_out[0]));
  c_reload: cover property (sw_reset[0] ##[1:8] sw_start[0]);
endmodule : gptc_top_chk
bind gptc_top gptc_top_chk #(.NCH(NCH), .CW(CW)) i_chk (
  .ref_clk(ref_clk), .resetn(resetn), .sw_start(sw_start), .sw_reset(sw_reset),
  .dir_sw_sel(dir_sw_sel), .sw_dir_up(sw_dir_up), .out_pol_low(out_pol_low),
  .mode_sel(mode_sel), .init_count(init_count), .count_value(count_value),
  .counter_pulse_out(counter_pulse_out), .meas_done(meas_done), .running(running));
`default_nettype wire

//--- bench/gptc_pins.sv
`timescale 1ns/10ps
`default_nettype none
// far-side pin sources, paced by the reference clock
module gptc_pins (
  // pacing clock
  input wire logic ref_clk,
  // pins into the block
  output var logic [1:0] clk_pin,
  output var logic [1:0] gate_pin,
  output var logic [1:0] dir_pin
);
  // all pins start low
  initial begin
    clk_pin = 2'h0;
    gate_pin = 2'h0;
    dir_pin = 2'h0;
  end
  // one clock pulse, 50 ns high and at least 55 ns low, inside the 10 MHz limit
  task tick(input int ch);
    @(posedge ref_clk);
    clk_pin[ch] <= 1'b1;
    repeat (5) @(posedge ref_clk);
    clk_pin[ch] <= 1'b0;
    repeat (5) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask : tick
  // direction level, held until the block has seen it
  task set_dir(input int ch, input logic v);
    @(posedge ref_clk);
    dir_pin[ch] <= v;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask : set_dir
  // gate level, held until the block has seen it
  task set_gate(input int ch, input logic v);
    @(posedge ref_clk);
    gate_pin[ch] <= v;
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask : set_gate
endmodule : gptc_pins
`default_nettype wire

//--- bench/gptc_bench.sv
`timescale 1ns/10ps
`default_nettype none
// integer model of channels 0 and 1 against the block
module general_purpose_timer_counter_bench;
  // clock, reset and controls
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic [1:0] sw_start = 2'h0, sw_reset = 2'h0, clk_src_ext = 2'h3, dir_sw_sel = 2'h3;
  logic [1:0] sw_dir_up = 2'h3, gate_sw_sel = 2'h0, sw_gate = 2'h0, clk_pol_low = 2'h0;
  logic [1:0] gate_pol_low = 2'h1, dir_pol_low = 2'h0, out_pol_low = 2'h0;
  logic [1:0][2:0] mode_sel = '0;
  logic [1:0][15:0] init_count = '0, pulse_delay = '0, pulse_width = '0, count_value;
  // pins and status
  logic [1:0] clk_pin, gate_pin, dir_pin, pulse_out, meas_done, running;
  // model state and tallies
  int fail_count = 0;
  int n_checks = 0;
  int m_cnt, m_init, n, d, w, md, k;
  logic [15:0] snap;
  always #5 ref_clk = ~ref_clk;
  gptc_pins i_pins (.ref_clk(ref_clk), .clk_pin(clk_pin), .gate_pin(gate_pin), .dir_pin(dir_pin));
  gptc_top #(.INT_DIV(4)) i_dut (.ref_clk(ref_clk), .resetn(resetn), .counter_clock_in(clk_pin),
    .counter_gate_in(gate_pin), .count_direction_in(dir_pin), .counter_pulse_out(pulse_out),
    .sw_start(sw_start), .sw_reset(sw_reset), .clk_src_ext(clk_src_ext), .dir_sw_sel(dir_sw_sel),
    .sw_dir_up(sw_dir_up), .gate_sw_sel(gate_sw_sel), .sw_gate(sw_gate), .clk_pol_low(clk_pol_low),
    .gate_pol_low(gate_pol_low), .dir_pol_low(dir_pol_low), .out_pol_low(out_pol_low),
    .mode_sel(mode_sel), .init_count(init_count), .pulse_delay(pulse_delay),
    .pulse_width(pulse_width), .count_value(count_value), .meas_done(meas_done), .running(running));
  // compare one result with the model
  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // one-cycle command on channel 0: reset when rst, else start
  task cmd(input logic rst);
    @(posedge ref_clk);
    sw_reset[0] <= rst;
    sw_start[0] <= !rst;
    @(posedge ref_clk);
    sw_reset[0] <= 1'b0;
    sw_start[0] <= 1'b0;
    repeat (2) @(negedge ref_clk);
  endtask : cmd
  // tallies, verdict and end of run
  task give_verdict;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict
  // watchdog, about twenty times the expected run
  initial begin
    #300000;
    fail_count++;
    give_verdict();
  end
  // main sequence
  initial begin
    void'($urandom(32'h0000_cae6));
    repeat (12) @(posedge ref_clk);
    resetn <= 1'b1;
    @(negedge ref_clk);
    chk("reset pins", 16'h0000, 16'(pulse_out));
    m_init = $urandom_range(16'hfff0, 16'h0010);
    m_cnt = m_init;
    @(posedge ref_clk);
    init_count[0] <= 16'(m_init);
    cmd(1'b1);
    i_pins.tick(0);
    chk("halted count", 16'(m_cnt), count_value[0]);
    // gated events, pin gate active low, counting up
    cmd(1'b0);
    n = $urandom_range(8, 1);
    repeat (n) i_pins.tick(0);
    m_cnt += n;
    chk("up count", 16'(m_cnt), count_value[0]);
    i_pins.set_gate(0, 1'b1);
    repeat (3) i_pins.tick(0);
    chk("gated hold", 16'(m_cnt), count_value[0]);
    // software gate, pin direction low counts down
    @(posedge ref_clk);
    gate_sw_sel[0] <= 1'b1;
    sw_gate[0] <= 1'b1;
    dir_sw_sel[0] <= 1'b0;
    repeat (n) i_pins.tick(0);
    m_cnt -= n;
    chk("down count", 16'(m_cnt), count_value[0]);
    chk("event pin", 16'h0000, 16'(pulse_out[0]));
    // internal tick, one step per four reference cycles
    @(posedge ref_clk);
    clk_src_ext[0] <= 1'b0;
    @(negedge ref_clk);
    snap = count_value[0];
    repeat (40) @(negedge ref_clk);
    chk("internal steps", 16'h000a, snap - count_value[0]);
    cmd(1'b1);
    @(posedge ref_clk);
    clk_src_ext[0] <= 1'b1;
    i_pins.tick(0);
    chk("reload", 16'(m_init), count_value[0]);
    chk("halted", 16'h0000, 16'(running[0]));
    $display("test counting done");
    // period and width measurement from zero
    for (md = 1; md <= 2; md++) begin
      @(posedge ref_clk);
      mode_sel[0] <= 3'(md);
      init_count[0] <= 16'h0000;
      gate_sw_sel[0] <= 1'b0;
      gate_pol_low[0] <= 1'b0;
      dir_sw_sel[0] <= 1'b1;
      i_pins.set_gate(0, 1'b0);
      cmd(1'b1);
      cmd(1'b0);
      i_pins.set_gate(0, 1'b1);
      n = $urandom_range(6, 2);
      repeat (n) i_pins.tick(0);
      i_pins.set_gate(0, 1'b0);
      // period mode counts the low half too, closed by the next rise
      if (md == 1) begin
        i_pins.tick(0);
        n++;
        i_pins.set_gate(0, 1'b1);
      end
      chk("measured", 16'(n), count_value[0]);
      chk("measure pin", 16'h0001, 16'(pulse_out[0]));
      $display("test measure %0d done", md);
    end
    // delayed pulse modes, output inverted in the last
    for (md = 3; md <= 7; md++) begin
      d = $urandom_range(3, 1);
      w = $urandom_range(4, 2);
      cmd(1'b1);
      @(posedge ref_clk);
      mode_sel[0] <= 3'(md);
      pulse_delay[0] <= 16'(d);
      pulse_width[0] <= 16'(w);
      out_pol_low[0] <= (md == 7);
      i_pins.set_gate(0, 1'b0);
      cmd(1'b1);
      cmd(1'b0);
      i_pins.set_gate(0, 1'b1);
      for (k = 1; k <= 2 * (d + w); k++) begin
        i_pins.tick(0);
        n = ((k % (d + w) >= d) && (md >= 6 || k < d + w)) ^ (md == 7);
        chk("pulse pin", 16'(n), 16'(pulse_out[0]));
      end
      // a second gate edge: only the retriggered mode answers
      if (md == 4 || md == 5) begin
        i_pins.set_gate(0, 1'b0);
        i_pins.set_gate(0, 1'b1);
        for (k = 1; k < d + w; k++) begin
          i_pins.tick(0);
          n = (md == 5) && (k >= d);
          chk("retrigger pin", 16'(n), 16'(pulse_out[0]));
        end
      end
      n = (md == 3 || md == 4);
      chk("single done", 16'(n), 16'(meas_done[0]));
      $display("test pulse mode %0d done", md);
    end
    chk("other channel", 16'h0000, count_value[1]);
    // channel 1: falling clock edge, software down, then pin direction active low
    snap = count_value[0];
    @(posedge ref_clk);
    clk_pol_low <= 2'h2;
    sw_dir_up <= 2'h1;
    init_count[1] <= 16'(m_init);
    sw_reset[1] <= 1'b1;
    @(posedge ref_clk);
    sw_reset[1] <= 1'b0;
    sw_start[1] <= 1'b1;
    @(posedge ref_clk);
    sw_start[1] <= 1'b0;
    i_pins.set_gate(1, 1'b1);
    n = $urandom_range(8, 1);
    repeat (n) i_pins.tick(1);
    m_cnt = m_init - n;
    chk("soft down", 16'(m_cnt), count_value[1]);
    @(posedge ref_clk);
    dir_sw_sel[1] <= 1'b0;
    dir_pol_low <= 2'h2;
    repeat (n) i_pins.tick(1);
    m_cnt += n;
    chk("pin dir low", 16'(m_cnt), count_value[1]);
    i_pins.set_dir(1, 1'b1);
    repeat (n) i_pins.tick(1);
    m_cnt -= n;
    chk("pin dir high", 16'(m_cnt), count_value[1]);
    // software gate held inactive stops counting
    @(posedge ref_clk);
    gate_sw_sel[1] <= 1'b1;
    repeat (3) i_pins.tick(1);
    chk("soft gate off", 16'(m_cnt), count_value[1]);
    chk("channel 0 held", snap, count_value[0]);
    $display("test channel 1 done");
    give_verdict();
  end
endmodule : general_purpose_timer_counter_bench
`default_nettype wire
